// [dual_clock_fifo.sv]
`timescale 1ns/1ps

// Notes on behaviour
// - A write_clock rise with write enable low stores the input word.
// - A read_clock rise with read enable low presents the next word.
// - Output drivers off unless output enable; cascaded, only the read-enabled part drives.
// - Writes while full and reads while empty are ignored.
// - While empty the last valid read word stays on the outputs.
// - Master reset gives empty state: boundary low, almost low, half high.
// - Read data outputs go low when master reset rises.
// - Write during master reset loads the configuration word.
// - Read during master reset outputs the configuration word, default before any load.
// - Low six configuration bits give almost distance in steps of sixteen.
// - Default distance is one step, sixteen words or locations.
// - Almost flag is unavailable when cascaded for depth.
// - Upper three configuration bits select parity; default is disabled.
// - Even generation gives low parity for an even count of ones.
// - Empty and almost-empty change only on read_clock rises.
// - Half, almost-full and full change only on write_clock rises.
// - Three flags encode six fill states.
// - Thresholds follow the depth; above half starts at half plus one.
// - At exactly half, the next enabled write drives half flag low.
// - A write_clock rise without enable still refreshes full-side flags.
// - Leaving above-half needs the reads seen before a write_clock update.
// - Opposite-port operations count only if done before the updating edge.
// - Distance ranges 0 to 15 here; zero makes almost-empty equal empty.
// - A read edge while flagged empty only refreshes empty, almost-empty and the read count.
// - Enabled update cycles move data and count; disabled ones only refresh count and flags.

module dual_clock_fifo
	import fifo_pkg::*;
#(
	parameter logic [2:0] PAR_EVEN_GEN = `PAR_CODE_EVEN_GEN,
	parameter logic [2:0] PAR_ODD_GEN = `PAR_CODE_ODD_GEN,
	parameter logic [2:0] PAR_EVEN_CHK = `PAR_CODE_EVEN_CHK,
	parameter logic [2:0] PAR_ODD_CHK = `PAR_CODE_ODD_CHK
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic write_clock,
	input wire logic write_enable_n,
	input wire logic [`FIFO_WIDTH-1:0] write_data,
	input wire logic read_clock,
	input wire logic read_enable_n,
	input wire logic output_enable_n,
	input wire logic master_reset_n,
	output logic [`FIFO_WIDTH-1:0] read_data,
	output logic [`FIFO_WIDTH-1:0] read_data_oe,
	output flags_t flags,
	output logic parity_error_out
);

	////////////////////////////////////////////////////////////////////////////////

	state_t s_q;
	state_t s_d;
	logic w_rise;
	logic r_rise;
	logic mem_we;
	logic mem_re;
	logic [`FIFO_WIDTH-1:0] mem_rdata;
	logic [`FIFO_PW-1:0] thr;
	logic [`FIFO_PW-1:0] cnt_w;
	logic [`FIFO_PW-1:0] cnt_r;
	logic [`FIFO_PW-1:0] wptr_nx;
	logic [`FIFO_PW-1:0] rptr_nx;
	logic [`FIFO_WIDTH-1:0] word;
	logic [11:0] addr;

	////////////////////////////////////////////////////////////////////////////////

	// Parity option decode; used for both the output word and the check flag.
	function automatic par_mode_t par_mode(input logic [2:0] code);
		par_mode_t m;
		m = PAR_OFF;
		if (code == PAR_EVEN_GEN || code == PAR_ODD_GEN)
		begin
			m = PAR_GEN;
		end
		else if (code == PAR_EVEN_CHK || code == PAR_ODD_CHK)
		begin
			m = PAR_CHECK;
		end
		return m;
	endfunction : par_mode

	function automatic logic par_odd(input logic [2:0] code);
		return (code == PAR_ODD_GEN) || (code == PAR_ODD_CHK);
	endfunction : par_odd

	// Register decode for the error answer; the read path decodes the offsets in its own case.
	function automatic logic mapped(input logic [11:0] a);
		return (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_WCOUNT) ||
			(a == `REG_RCOUNT) || (a == `REG_CONFIG);
	endfunction : mapped

	////////////////////////////////////////////////////////////////////////////////

	// Port clocks arrive synchronous to core_clk, so one stored sample finds their rises.
	assign w_rise = write_clock & ~s_q.wclk_prev;
	assign r_rise = read_clock & ~s_q.rclk_prev;
	assign addr = apb_req.paddr[11:0];

	always_comb
	begin
		logic [5:0] p;
		p = s_q.cfg[`CFG_DIST_MSB:`CFG_DIST_LSB];
		if (p > `DIST_MAX)
		begin
			p = `DIST_MAX;
		end
		thr = {p, 4'h0};
	end

	// Each port sees the other pointer only as it stood before its own edge, so an
	// opposite operation in the same cycle falls into the next update.
	// opposite edge inclusion
	assign wptr_nx = s_q.wptr + `FIFO_PW'(mem_we);
	assign rptr_nx = s_q.rptr + `FIFO_PW'(mem_re);
	assign cnt_w = wptr_nx - s_q.rptr;
	assign cnt_r = s_q.wptr - rptr_nx;

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_d = s_q;
		s_d.wclk_prev = write_clock;
		s_d.rclk_prev = read_clock;
		s_d.mr_prev = master_reset_n;
		s_d.rd_pend = 1'b0;
		mem_we = 1'b0;
		mem_re = 1'b0;
		word = mem_rdata;

		// Word fetched on the previous cycle lands in the output register.
		// parity option
		if (s_q.rd_pend)
		begin
			if (par_mode(s_q.cfg[`CFG_PAR_MSB:`CFG_PAR_LSB]) == PAR_GEN)
			begin
				word[8] = (^mem_rdata[7:0]) ^ par_odd(s_q.cfg[`CFG_PAR_MSB:`CFG_PAR_LSB]);
			end
			s_d.dout = word;
			s_d.perr = 1'b0;
			if (par_mode(s_q.cfg[`CFG_PAR_MSB:`CFG_PAR_LSB]) == PAR_CHECK)
			begin
				s_d.perr = (^mem_rdata) ^ par_odd(s_q.cfg[`CFG_PAR_MSB:`CFG_PAR_LSB]);
			end
		end

		if (!master_reset_n)
		begin
			s_d.wptr = '0;
			s_d.rptr = '0;
			s_d.wcount = '0;
			s_d.rcount = '0;
			s_d.empty = 1'b1;
			s_d.aempty = 1'b1;
			s_d.full = 1'b0;
			s_d.afull = 1'b0;
			s_d.hfull = 1'b0;
			s_d.rd_pend = 1'b0;
			if (s_q.mr_prev)
			begin
				s_d.cfg = `CFG_DEFAULT;
			end
			if (w_rise && !write_enable_n)
			begin
				s_d.cfg = write_data;
			end
			if (r_rise && !read_enable_n)
			begin
				s_d.dout = s_q.cfg;
			end
		end
		else
		begin
			if (!s_q.mr_prev)
			begin
				s_d.dout = '0;
				s_d.perr = 1'b0;
			end

			// Write port: store, then refresh the full-side flags on every rise.
			if (w_rise)
			begin
				if (!write_enable_n && !s_q.full)
				begin
					mem_we = 1'b1;
				end
				s_d.wptr = wptr_nx;
				s_d.wcount = cnt_w;
				s_d.full = (cnt_w == `FIFO_DEPTH);
				s_d.afull = ((`FIFO_DEPTH - cnt_w) <= thr);
				s_d.hfull = (cnt_w > `FIFO_HALF);
			end

			// Read port: while flagged empty the edge only refreshes the flags and rcount.
			if (r_rise)
			begin
				if (!read_enable_n && !s_q.empty)
				begin
					mem_re = 1'b1;
					s_d.rd_pend = 1'b1;
				end
				s_d.rptr = rptr_nx;
				s_d.rcount = cnt_r;
				s_d.empty = (cnt_r == '0);
				s_d.aempty = (cnt_r <= thr);
			end
		end

		// APB: read data is taken in the setup cycle so the zero-wait access is valid.
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
		begin
			s_d.prdata = '0;
			case (addr)
				`REG_CTRL:
				begin
					s_d.prdata[`CTRL_CASCADE] = s_q.cascade;
				end
				`REG_STATUS:
				begin
					s_d.prdata[4:0] = {s_q.hfull, s_q.afull, s_q.full, s_q.aempty, s_q.empty};
					s_d.prdata[5] = s_q.perr;
					s_d.prdata[6] = ~master_reset_n;
				end
				`REG_WCOUNT:
				begin
					s_d.prdata[`FIFO_PW-1:0] = s_q.wcount;
				end
				`REG_RCOUNT:
				begin
					s_d.prdata[`FIFO_PW-1:0] = s_q.rcount;
				end
				`REG_CONFIG:
				begin
					s_d.prdata[`FIFO_WIDTH-1:0] = s_q.cfg;
				end
				default:
				begin
					s_d.prdata = '0;
				end
			endcase
		end
		if (apb_req.psel && apb_req.penable && apb_req.pwrite && addr == `REG_CTRL)
		begin
			s_d.cascade = apb_req.pwdata[`CTRL_CASCADE];
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			s_q <= '0;
			s_q.mr_prev <= 1'b1;
			s_q.empty <= 1'b1;
			s_q.aempty <= 1'b1;
			s_q.cfg <= `CFG_DEFAULT;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	fifo_mem u_mem (
		.core_clk(core_clk),
		.we(mem_we),
		.waddr(s_q.wptr[`FIFO_AW-1:0]),
		.wdata(write_data),
		.re(mem_re),
		.raddr(s_q.rptr[`FIFO_AW-1:0]),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////

	assign prdata = s_q.prdata;
	assign pready = 1'b1;
	assign pslverr = apb_req.psel & apb_req.penable & ~mapped(addr);

	assign read_data = s_q.dout;
	assign parity_error_out = s_q.perr;

	assign read_data_oe = {`FIFO_WIDTH{~output_enable_n & (~s_q.cascade | ~read_enable_n)}};

	assign flags.boundary_flag_n = ~(s_q.empty | s_q.full);
	assign flags.almost_level_flag_n = s_q.cascade | ~(s_q.aempty | s_q.afull);
	assign flags.half_level_flag_n = ~s_q.hfull;

endmodule : dual_clock_fifo

// [fifo_consts.svh]
`ifndef FIFO_CONSTS_SVH
`define FIFO_CONSTS_SVH

// Storage shape.
`define FIFO_WIDTH 9
`define FIFO_AW 9
`define FIFO_PW 10
`define FIFO_DEPTH 10'h200
`define FIFO_HALF 10'h100

// Configuration word layout and default.
`define CFG_DEFAULT 9'h001
`define CFG_DIST_LSB 0
`define CFG_DIST_MSB 5
`define CFG_PAR_LSB 6
`define CFG_PAR_MSB 8
`define DIST_MAX 6'h0F

// Parity option codes in the upper three configuration bits.
`define PAR_CODE_EVEN_GEN 3'h1
`define PAR_CODE_ODD_GEN 3'h2
`define PAR_CODE_EVEN_CHK 3'h3
`define PAR_CODE_ODD_CHK 3'h4

// APB register offsets (byte addresses).
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_WCOUNT 12'h008
`define REG_RCOUNT 12'h00C
`define REG_CONFIG 12'h010

// Field positions.
`define CTRL_CASCADE 0

`endif

// [fifo_pkg.sv]
package fifo_pkg;

`include "fifo_consts.svh"

typedef struct packed {
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
} apb_req_t;

typedef struct packed {
	logic boundary_flag_n;
	logic almost_level_flag_n;
	logic half_level_flag_n;
} flags_t;

typedef enum logic [1:0] {
	PAR_OFF,
	PAR_GEN,
	PAR_CHECK
} par_mode_t;

typedef struct packed {
	logic wclk_prev;
	logic rclk_prev;
	logic mr_prev;
	logic [`FIFO_PW-1:0] wptr;
	logic [`FIFO_PW-1:0] rptr;
	logic [`FIFO_PW-1:0] wcount;
	logic [`FIFO_PW-1:0] rcount;
	logic empty;
	logic aempty;
	logic full;
	logic afull;
	logic hfull;
	logic [`FIFO_WIDTH-1:0] cfg;
	logic rd_pend;
	logic [`FIFO_WIDTH-1:0] dout;
	logic perr;
	logic cascade;
	logic [31:0] prdata;
} state_t;

endpackage : fifo_pkg

// [fifo_mem.sv]
`timescale 1ns/1ps

module fifo_mem
	import fifo_pkg::*;
(
	input wire logic core_clk,
	input wire logic we,
	input wire logic [`FIFO_AW-1:0] waddr,
	input wire logic [`FIFO_WIDTH-1:0] wdata,
	input wire logic re,
	input wire logic [`FIFO_AW-1:0] raddr,
	output logic [`FIFO_WIDTH-1:0] rdata
);

	logic [`FIFO_WIDTH-1:0] mem [0:(1 << `FIFO_AW)-1];

	// Read data leaves through a register so the array maps onto block RAM.
	always_ff @(posedge core_clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		if (re)
		begin
			rdata <= mem[raddr];
		end
	end

endmodule : fifo_mem

// [fifo_far_end.sv]
`timescale 1ns/1ps

module fifo_far_end
(
	input wire logic core_clk,
	output logic write_clock = 1'b0,
	output logic write_enable_n = 1'b1,
	output logic [8:0] write_data = 9'h000,
	output logic read_clock = 1'b0,
	output logic read_enable_n = 1'b1
);
	// one pulse every two cycles, so no strobe lands beside a program load.
	task automatic wr(input logic en, input logic [8:0] d);
		@(posedge core_clk);
		write_clock <= 1'b1;
		write_enable_n <= ~en;
		write_data <= en ? d : ~write_data;
		@(posedge core_clk);
		write_clock <= 1'b0;
		write_enable_n <= 1'b1;
		write_data <= ~write_data;
	endtask : wr

	// reads are enabled only when the bench asks.
	task automatic rd(input logic en);
		@(posedge core_clk);
		read_clock <= 1'b1;
		read_enable_n <= ~en;
		@(posedge core_clk);
		read_clock <= 1'b0;
		read_enable_n <= 1'b1;
	endtask : rd
endmodule : fifo_far_end

// [fifo_asserts.sv]
`timescale 1ns/1ps
`include "fifo_consts.svh"

module fifo_asserts
	import fifo_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire apb_req_t apb_req,
	input wire logic pslverr,
	input wire logic write_clock,
	input wire logic read_clock,
	input wire logic read_enable_n,
	input wire logic output_enable_n,
	input wire logic master_reset_n,
	input wire logic [`FIFO_WIDTH-1:0] read_data,
	input wire logic [`FIFO_WIDTH-1:0] read_data_oe,
	input wire flags_t flags
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	chk_oe_off:
	assert property (output_enable_n |-> read_data_oe == 9'h000) else $error("oe off drives");
	chk_oe_read:
	assert property (!output_enable_n && !read_enable_n |-> read_data_oe == 9'h1FF)
		else $error("oe on not driving");
	chk_reset_empty:
	assert property (!master_reset_n |=> flags == 3'h1) else $error("reset flags");
	chk_reset_low:
	assert property ($rose(master_reset_n) |=> read_data == 9'h000) else $error("data not low");
	chk_empty_hold:
	assert property (flags == 3'h1 && $rose(read_clock) && master_reset_n
		|=> ##1 $stable(read_data)[*2]) else $error("empty read moved data");
	chk_empty_side:
	assert property ($past(flags) == 3'h1 && flags.boundary_flag_n
		|-> $past(read_clock) && !$past(read_clock, 2)) else $error("empty left off read");
	chk_full_side:
	assert property ($past(flags) == 3'h0 && flags.boundary_flag_n && $past(master_reset_n)
		|-> $past(write_clock) && !$past(write_clock, 2)) else $error("full left off write");
	chk_half_write:
	assert property ($fell(flags.half_level_flag_n)
		|-> $past(write_clock) && !$past(write_clock, 2)) else $error("half off write");
	chk_bus_err:
	assert property (apb_req.psel && apb_req.penable |-> pslverr == !(apb_req.paddr[11:0] inside
		{`REG_CTRL, `REG_STATUS, `REG_WCOUNT, `REG_RCOUNT, `REG_CONFIG}))
		else $error("bus error wrong");
	cover property (flags == 3'h0);
	cover property (flags == 3'h1 && $rose(read_clock) && !read_enable_n);
	cover property ($rose(master_reset_n));
endmodule : fifo_asserts

bind dual_clock_fifo fifo_asserts u_chk (.core_clk, .rst_b, .apb_req, .pslverr, .write_clock,
	.read_clock, .read_enable_n, .output_enable_n, .master_reset_n, .read_data, .read_data_oe,
	.flags);

// [tb_dual_clock_fifo_prog_flags.sv]
`timescale 1ns/1ps
`include "fifo_consts.svh"

module tb_dual_clock_fifo_prog_flags
	import fifo_pkg::*;
	;
	logic core_clk = 1'b0;
	logic rst_b, output_enable_n, master_reset_n, pready, pslverr, write_clock, write_enable_n;
	logic read_clock, read_enable_n, parity_error_out, e;
	logic rq = 1'b0;
	logic [2:0] pipe = 3'h0;
	logic [2:0] mode;
	logic [8:0] write_data, read_data, read_data_oe;
	logic [9:0] last;
	logic [9:0] exq[$];
	logic [9:0] mq[$];
	logic [31:0] prdata, r;
	apb_req_t apb_req;
	flags_t flags;
	int err_count = 0;
	int checks_done = 0;
	int cnt;

	dual_clock_fifo u_dut (.core_clk, .rst_b, .apb_req, .prdata, .pready, .pslverr, .write_clock,
		.write_enable_n, .write_data, .read_clock, .read_enable_n, .output_enable_n,
		.master_reset_n, .read_data, .read_data_oe, .flags, .parity_error_out);
	fifo_far_end u_far (.core_clk, .write_clock, .write_enable_n, .write_data, .read_clock,
		.read_enable_n);

	initial forever #20 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : cmp

	function automatic flags_t fexp(input int n, input int p);
		if (n == 0) return 3'h1;
		if (n <= 32'h10 * p) return 3'h5;
		if (n <= `FIFO_HALF) return 3'h7;
		if (n == `FIFO_DEPTH) return 3'h0;
		if (n < `FIFO_DEPTH - 32'h10 * p) return 3'h6;
		return 3'h4;
	endfunction : fexp

	// expected word and error bit per parity mode.
	function automatic logic [9:0] oexp(input logic [8:0] d);
		case (mode)
			`PAR_CODE_EVEN_GEN: return {1'b0, ^d[7:0], d[7:0]};
			`PAR_CODE_ODD_GEN: return {1'b0, ~^d[7:0], d[7:0]};
			`PAR_CODE_EVEN_CHK: return {^d, d};
			`PAR_CODE_ODD_CHK: return {~^d, d};
			default: return {1'b0, d};
		endcase
	endfunction : oexp

	task automatic push;
		logic [8:0] d;
		d = 9'($urandom);
		u_far.wr(1'b1, d);
		if (cnt < `FIFO_DEPTH)
		begin
			mq.push_back(oexp(d));
			cnt++;
		end
	endtask : push

	task automatic fill(input int n, input int p);
		repeat (n)
		begin
			push();
			u_far.rd(1'b0);
			@(negedge core_clk);
			cmp(flags, fexp(cnt, p), "fill flags");
		end
	endtask : fill

	task automatic drain(input int n, input int p);
		repeat (n)
		begin
			if (cnt > 0)
			begin
				last = mq.pop_front();
				cnt--;
			end
			exq.push_back(last);
			u_far.rd(1'b1);
			u_far.wr(1'b0, 9'h000);
			@(negedge core_clk);
			cmp(flags, fexp(cnt, p), "drain flags");
		end
	endtask : drain

	// port traffic during reset is only the default read, the program write and its readback read.
	task automatic prog(input logic [8:0] c);
		@(posedge core_clk);
		master_reset_n <= 1'b0;
		u_far.rd(1'b1);
		repeat (2) @(negedge core_clk);
		cmp(read_data, `CFG_DEFAULT, "default cfg");
		u_far.wr(1'b1, c);
		u_far.rd(1'b1);
		repeat (2) @(negedge core_clk);
		cmp(read_data, c, "cfg readback");
		cmp(flags, 3'h1, "reset flags");
		@(posedge core_clk);
		master_reset_n <= 1'b1;
		repeat (2) @(negedge core_clk);
		cmp(read_data, 9'h000, "outputs low");
		mode = c[8:6];
	endtask : prog

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int i;
		@(posedge core_clk);
		apb_req.psel <= 1'b1;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= wd;
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1)
		begin
			err_count++;
			close_out();
		end
		r = prdata;
		e = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	always @(posedge core_clk)
	begin
		rq <= read_clock;
		pipe <= {pipe[1:0], read_clock & ~rq & ~read_enable_n & master_reset_n};
		if (pipe[2])
			cmp({parity_error_out, read_data}, exq.pop_front(), "read word");
	end

	initial
	begin
		repeat (60000) @(posedge core_clk);
		err_count++;
		close_out();
	end

	initial
	begin
		void'($urandom(32'h263562C1));
		rst_b = 1'b0;
		master_reset_n = 1'b1;
		output_enable_n = 1'b1;
		apb_req = '0;
		mode = 3'h0;
		cnt = 0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		fill(513, 1);
		drain(513, 1);
		for (int k = 0; k < 5; k++)
		begin
			prog({k[2:0], 6'(k)});
			fill(16 * k + 1, k);
			drain(16 * k + 1, k);
		end
		apb(1'b1, `REG_CTRL, 32'h1);
		push();
		u_far.rd(1'b0);
		output_enable_n <= 1'b0;
		@(negedge core_clk);
		cmp(flags, 3'h7, "cascade flags");
		cmp(read_data_oe, 9'h000, "cascade drive");
		apb(1'b0, `REG_STATUS, 32'h0);
		cmp(r[0], 1'b0, "status empty");
		apb(1'b0, `REG_CONFIG, 32'h0);
		cmp(r, 32'h104, "config reg");
		apb(1'b0, 32'h20, 32'h0);
		cmp(e, 1'b1, "unmapped err");
		cmp(r, 32'h0, "unmapped data");
		apb(1'b1, `REG_CTRL, 32'h0);
		@(negedge core_clk);
		cmp(read_data_oe, 9'h1FF, "standalone drive");
		repeat (4) @(posedge core_clk);
		cmp(exq.size(), 0, "words left");
		close_out();
	end
endmodule : tb_dual_clock_fifo_prog_flags
